/* pwmb_pkg.sv */
/*
 * Constants for the generator B timing core: register indices and byte
 * addresses, field positions, reset values and prescaler codes.
 * Assumes a 32-bit APB slave with 12-bit byte addresses.
 */
// How it works
// - Frequency-control, counter and modulus registers always readable; enable control reads zero and writes are ignored unless multi-generator mode set.
// - Reload interval field schedules a reload every N+1 load opportunities.
// - New interval takes effect when current load cycle ends; reads give buffered value.
// - Half-cycle bit adds half-period opportunities in center-aligned mode only.
// - Prescaler field picks bus clock divided by 1, 2, 4 or 8.
// - Written prescaler is buffered and applied at next reload with load-okay.
// - Reload flag is set at every reload regardless of load-okay.
// - Flag clears by read-while-set then write one; a reload in between blocks it.
// - Clearing the reload flag withdraws the pending interrupt request.
// - Counter register shows the live 15-bit counter; writes do nothing.
// - Active modulus is the period in PWM clock periods in edge-aligned mode, and half the period in center-aligned mode.
// - Written modulus stays buffered until load-okay and the next load cycle.
// - Load-okay set by read-as-zero then write one, cleared by write zero or reload.
// - Reload flag raises the interrupt only while its enable bit is set.

`default_nettype none

package pwmb_pkg;

    // ----------------------------------------------------------------
    // Bus geometry and field widths
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W = 32;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned CNT_W  = 15;
    localparam int unsigned IVL_W  = 4;
    localparam int unsigned PSC_W  = 2;

    // ----------------------------------------------------------------
    // Register indices; the byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [9:0] IDX_ENABLE_CTRL = 10'h028;
    localparam logic [9:0] IDX_FREQ_CTRL   = 10'h029;
    localparam logic [9:0] IDX_COUNTER     = 10'h02a;
    localparam logic [9:0] IDX_MODULUS     = 10'h02c;

    localparam logic [ADDR_W-1:0] ADDR_ENABLE_CTRL = {IDX_ENABLE_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_FREQ_CTRL   = {IDX_FREQ_CTRL, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_COUNTER     = {IDX_COUNTER, 2'b00};
    localparam logic [ADDR_W-1:0] ADDR_MODULUS     = {IDX_MODULUS, 2'b00};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned ENC_EN_BIT   = 7;
    localparam int unsigned ENC_LOAD_OKAY_BIT = 1;
    localparam int unsigned ENC_RIE_BIT  = 0;
    localparam int unsigned FQC_IVL_LSB  = 4;
    localparam int unsigned FQC_HALF_BIT = 3;
    localparam int unsigned FQC_PSC_LSB  = 1;
    localparam int unsigned FQC_FLAG_BIT = 0;

    // ----------------------------------------------------------------
    // Reset value of every state field, and prescaler codes
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] RST_ALL_ZERO = 32'h0000_0000;
    localparam logic [PSC_W-1:0]  PSC_DIV1     = 2'h0;
    localparam logic [PSC_W-1:0]  PSC_DIV2     = 2'h1;
    localparam logic [PSC_W-1:0]  PSC_DIV4     = 2'h2;
    localparam logic [PSC_W-1:0]  PSC_DIV8     = 2'h3;

endpackage

`default_nettype wire

/* pwmb_tick_if.sv */
/*
 * Carrier between the generator core and its prescaler: divider select,
 * divider clear and the PWM clock enable pulse.
 * Assumes both ends run on the same bus clock.
 */
`default_nettype none

interface pwmb_tick_if;
    import pwmb_pkg::*;

    logic [PSC_W-1:0] sel;
    logic             clr;
    logic             tick;

    modport ctrl (output sel, output clr, input tick);
    modport div  (input sel, input clr, output tick);
endinterface

`default_nettype wire

/* pwmb_prescaler.sv */
/*
 * Prescaler: turns the bus clock into a one-cycle PWM clock enable at
 * 1, 1/2, 1/4 or 1/8 of the bus rate.
 * Assumes the select only changes on a tick or while cleared.
 */
`default_nettype none

module pwmb_prescaler (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Divider carrier
    pwmb_tick_if.div  tk
);
    import pwmb_pkg::*;

    typedef struct packed {
        logic [2:0] div_cnt;
        logic       tick;
    } pwmb_psc_state_t;

    pwmb_psc_state_t st_ff;
    pwmb_psc_state_t nxt_st;
    logic [2:0]      mask;

    always_comb begin
        case (tk.sel)
            PSC_DIV1: mask = 3'h0;
            PSC_DIV2: mask = 3'h1;
            PSC_DIV4: mask = 3'h3;
            PSC_DIV8: mask = 3'h7;
            default:  mask = 3'h7;
        endcase
        nxt_st = st_ff;
        if (tk.clr) begin
            nxt_st.div_cnt = 3'h0;
            nxt_st.tick    = 1'b0;
        end else begin
            nxt_st.tick    = ((st_ff.div_cnt & mask) == mask);
            nxt_st.div_cnt = st_ff.div_cnt + 3'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign tk.tick = st_ff.tick;

    a_prescale_eighth: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_ff.tick && tk.sel == PSC_DIV8 ##1 tk.sel == PSC_DIV8) |-> !st_ff.tick [*7])
        else $error("Divide-by-eight tick came early.");

    a_prescale_full: assert property (
        @(posedge clk) disable iff (!rst_b)
        (st_ff.tick && tk.sel == PSC_DIV1 && !tk.clr) |=> st_ff.tick)
        else $error("Undivided tick missed a cycle.");

endmodule

`default_nettype wire

/* pwmb_gen.sv */
/*
 * Generator B timing core: period counter, buffered modulus, prescaler
 * and reload interval, reload flag and interrupt, APB register slave.
 * Assumes the mode inputs come from logic on the same clock.
 */
`default_nettype none

module pwmb_gen #(
    parameter int unsigned CNT_WIDTH = pwmb_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_b,
    // APB slave
    input  wire logic [pwmb_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pwmb_pkg::DATA_W-1:0]   pwdata,
    output logic      [pwmb_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    // Module-wide mode
    input  wire logic                          multi_generator_mode,
    input  wire logic                          center_aligned,
    // Generator outputs
    output logic      [CNT_WIDTH-1:0]          counter_b,
    output logic                               reload_b,
    output logic                               irq_b
);
    import pwmb_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [CNT_WIDTH-1:0] cnt;
        logic                 dir_down;
        logic [CNT_WIDTH-1:0] mod_buf;
        logic [CNT_WIDTH-1:0] mod_act;
        logic [IVL_W-1:0]     ivl_buf;
        logic [IVL_W-1:0]     ivl_act;
        logic [IVL_W-1:0]     opp_cnt;
        logic                 half;
        logic [PSC_W-1:0]     psc_buf;
        logic [PSC_W-1:0]     psc_act;
        logic                 flag;
        logic                 flag_armed;
        logic                 load_okay;
        logic                 load_okay_armed;
        logic                 en;
        logic                 rie;
        logic [DATA_W-1:0]    prdata;
        logic                 pready;
        logic                 pslverr;
        logic                 irq;
        logic                 reload;
    } pwmb_state_t;

    pwmb_state_t          st_ff;
    pwmb_state_t          nxt_st;
    logic                 acc_setup;
    logic                 wr_done;
    logic                 rd_done;
    logic                 hit_enc;
    logic                 hit_fqc;
    logic                 hit_cnt;
    logic                 hit_mod;
    logic                 hit_any;
    logic                 wr_ok;
    logic [DATA_W-1:0]    rd_mux;
    logic [CNT_WIDTH-1:0] mod_last;
    logic                 period_end;
    logic                 half_point;
    logic                 opp_now;
    logic                 reload_now;

    pwmb_tick_if tk ();

    pwmb_prescaler u_psc (
        .clk   (clk),
        .rst_b (rst_b),
        .tk    (tk)
    );

    assign tk.sel = st_ff.psc_act;
    assign tk.clr = ~st_ff.en;

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    // One wait state keeps every bus output on a flop; the cost is one
    // extra cycle per access.
    assign acc_setup = psel & penable & ~st_ff.pready;
    assign wr_done   = psel & penable & st_ff.pready & pwrite;
    assign rd_done   = psel & penable & st_ff.pready & ~pwrite;
    assign hit_enc   = (paddr == ADDR_ENABLE_CTRL);
    assign hit_fqc   = (paddr == ADDR_FREQ_CTRL);
    assign hit_cnt   = (paddr == ADDR_COUNTER);
    assign hit_mod   = (paddr == ADDR_MODULUS);
    assign hit_any   = hit_enc | hit_fqc | hit_cnt | hit_mod;
    assign wr_ok     = wr_done & multi_generator_mode;

    always_comb begin
        rd_mux = RST_ALL_ZERO;
        if (hit_enc && multi_generator_mode) begin
            rd_mux[ENC_EN_BIT]   = st_ff.en;
            rd_mux[ENC_LOAD_OKAY_BIT] = st_ff.load_okay;
            rd_mux[ENC_RIE_BIT]  = st_ff.rie;
        end else if (hit_fqc) begin
            rd_mux[FQC_IVL_LSB +: IVL_W] = st_ff.ivl_buf;
            rd_mux[FQC_HALF_BIT]         = st_ff.half;
            rd_mux[FQC_PSC_LSB +: PSC_W] = st_ff.psc_buf;
            rd_mux[FQC_FLAG_BIT]         = st_ff.flag;
        end else if (hit_cnt) begin
            rd_mux[CNT_WIDTH-1:0] = st_ff.cnt;
        end else if (hit_mod) begin
            rd_mux[CNT_WIDTH-1:0] = st_ff.mod_buf;
        end
    end

    // ----------------------------------------------------------------
    // Period counter and load opportunities
    // ----------------------------------------------------------------
    // The active modulus is zero from reset until the first load with load-okay;
    // a zero makes the edge-aligned count wrap through the top of the range.
    assign mod_last   = st_ff.mod_act - CNT_WIDTH'(1);
    assign period_end = center_aligned ? (st_ff.dir_down && st_ff.cnt == '0) : (st_ff.cnt >= mod_last);
    assign half_point = center_aligned & ~st_ff.dir_down & (st_ff.cnt >= st_ff.mod_act);
    assign opp_now    = st_ff.en & tk.tick & (period_end | (half_point & st_ff.half));
    assign reload_now = opp_now & (st_ff.opp_cnt == st_ff.ivl_act);

    // A disabled generator holds its counter at zero and its prescaler cleared,
    // so the first PWM tick follows the enable by as many bus cycles as the divide ratio.
    always_comb begin
        nxt_st = st_ff;

        if (!st_ff.en) begin
            nxt_st.cnt      = '0;
            nxt_st.dir_down = 1'b0;
            nxt_st.opp_cnt  = '0;
        end else if (tk.tick) begin
            if (!center_aligned) begin
                nxt_st.dir_down = 1'b0;
                nxt_st.cnt      = period_end ? '0 : st_ff.cnt + CNT_WIDTH'(1);
            end else if (half_point) begin
                nxt_st.dir_down = 1'b1;
                nxt_st.cnt      = st_ff.cnt - CNT_WIDTH'(1);
            end else if (period_end) begin
                nxt_st.dir_down = 1'b0;
                nxt_st.cnt      = CNT_WIDTH'(1);
            end else if (st_ff.dir_down) begin
                nxt_st.cnt = st_ff.cnt - CNT_WIDTH'(1);
            end else begin
                nxt_st.cnt = st_ff.cnt + CNT_WIDTH'(1);
            end
        end

        if (opp_now) begin
            nxt_st.opp_cnt = reload_now ? '0 : st_ff.opp_cnt + IVL_W'(1);
        end

        if (reload_now) begin
            nxt_st.ivl_act    = st_ff.ivl_buf;
            nxt_st.flag       = 1'b1;
            nxt_st.flag_armed = 1'b0;
            if (st_ff.load_okay) begin
                nxt_st.mod_act = st_ff.mod_buf;
                nxt_st.psc_act = st_ff.psc_buf;
                nxt_st.load_okay    = 1'b0;
            end
        end

        // ------------------------------------------------------------
        // Register writes
        // ------------------------------------------------------------
        // Writes come after the reload so that a software set of load-okay
        // in the same cycle as its automatic clear is the one that survives.
        if (wr_ok && hit_enc) begin
            nxt_st.en         = pwdata[ENC_EN_BIT];
            nxt_st.rie        = pwdata[ENC_RIE_BIT];
            nxt_st.load_okay_armed = 1'b0;
            if (!pwdata[ENC_LOAD_OKAY_BIT]) begin
                nxt_st.load_okay = 1'b0;
            end else if (st_ff.load_okay_armed) begin
                nxt_st.load_okay = 1'b1;
            end
        end
        if (wr_ok && hit_fqc) begin
            nxt_st.ivl_buf    = pwdata[FQC_IVL_LSB +: IVL_W];
            nxt_st.half       = pwdata[FQC_HALF_BIT];
            nxt_st.psc_buf    = pwdata[FQC_PSC_LSB +: PSC_W];
            nxt_st.flag_armed = 1'b0;
            // A reload in the same cycle keeps the flag: set wins.
            if (pwdata[FQC_FLAG_BIT] && st_ff.flag_armed && !reload_now) begin
                nxt_st.flag = 1'b0;
            end
        end
        if (wr_ok && hit_mod) begin
            nxt_st.mod_buf = pwdata[CNT_WIDTH-1:0];
        end

        // ------------------------------------------------------------
        // Read side effects, taken from the data actually returned
        // ------------------------------------------------------------
        // Arming follows the returned data, so a clear can never be armed
        // against a flag value that software has not actually seen.
        if (rd_done && hit_fqc && st_ff.prdata[FQC_FLAG_BIT] && !reload_now) begin
            nxt_st.flag_armed = 1'b1;
        end
        if (rd_done && hit_enc && multi_generator_mode && !st_ff.prdata[ENC_LOAD_OKAY_BIT]) begin
            nxt_st.load_okay_armed = 1'b1;
        end

        nxt_st.pready  = acc_setup;
        nxt_st.pslverr = acc_setup & ~hit_any;
        nxt_st.prdata  = (acc_setup && !pwrite) ? rd_mux : RST_ALL_ZERO;
        nxt_st.reload  = reload_now;
        nxt_st.irq     = nxt_st.flag & nxt_st.rie;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata    = st_ff.prdata;
    assign pready    = st_ff.pready;
    assign pslverr   = st_ff.pslverr;
    assign counter_b = st_ff.cnt;
    assign reload_b  = st_ff.reload;
    assign irq_b     = st_ff.irq;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // The read-then-write checks expect one idle cycle after each transfer,
    // which gives three cycles between the read and the write; other spacings
    // are covered by the refusal checks below.
    sequence s_read_load_okay_zero;
        rd_done && hit_enc && multi_generator_mode && !st_ff.prdata[ENC_LOAD_OKAY_BIT];
    endsequence

    sequence s_write_one_load_okay;
        wr_ok && hit_enc && pwdata[ENC_LOAD_OKAY_BIT];
    endsequence

    sequence s_read_flag_set;
        rd_done && hit_fqc && st_ff.prdata[FQC_FLAG_BIT] && !reload_now;
    endsequence

    sequence s_write_one_flag;
        wr_done && hit_fqc && multi_generator_mode && pwdata[FQC_FLAG_BIT] && !reload_now;
    endsequence

    a_write_gated_mode: assert property (
        (wr_done && !multi_generator_mode) |=> $stable(st_ff.mod_buf) && $stable(st_ff.ivl_buf))
        else $error("Register write taken without multi-generator mode.");

    a_reload_interval: assert property (
        reload_now |-> (opp_now && st_ff.opp_cnt == st_ff.ivl_act))
        else $error("Reload not on the scheduled opportunity.");

    a_interval_takes: assert property (
        reload_now |=> st_ff.ivl_act == $past(st_ff.ivl_buf))
        else $error("Interval not applied at reload.");

    a_half_edge_none: assert property (
        (opp_now && !center_aligned) |-> st_ff.cnt >= mod_last)
        else $error("Opportunity inside an edge-aligned period.");

    a_prescale_buffered: assert property (
        (reload_now && !st_ff.load_okay) |=> $stable(st_ff.psc_act))
        else $error("Prescaler changed without load-okay.");

    a_flag_on_reload: assert property (
        reload_now |=> st_ff.flag && reload_b)
        else $error("Reload did not set the flag.");

    a_flag_clear_seq: assert property (
        (s_read_flag_set ##1 (!reload_now && !rd_done)[*3] ##1 s_write_one_flag) |=> !st_ff.flag)
        else $error("Read then write-one did not clear the flag.");

    a_load_okay_set_seq: assert property (
        (s_read_load_okay_zero ##1 (!(wr_done && hit_enc))[*3] ##1 s_write_one_load_okay) |=> st_ff.load_okay)
        else $error("Read-zero then write-one did not set load-okay.");

    a_load_okay_refused: assert property (
        (wr_done && hit_enc && !st_ff.load_okay_armed && !st_ff.load_okay) |=> !st_ff.load_okay)
        else $error("Load-okay set without a read of zero.");

    a_half_reload: assert property (
        (opp_now && !period_end) |-> (center_aligned && st_ff.half))
        else $error("Half-period opportunity without center alignment and half reloads.");

    a_prescale_loaded: assert property (
        (reload_now && st_ff.load_okay) |=> st_ff.psc_act == $past(st_ff.psc_buf))
        else $error("Buffered prescaler not loaded at reload.");

    a_counter_wrap: assert property (
        (opp_now && !center_aligned) |=> counter_b == '0)
        else $error("Edge-aligned counter did not restart at period end.");

    a_unmapped_err: assert property (
        (acc_setup && !hit_any) |=> pslverr && pready && prdata == RST_ALL_ZERO)
        else $error("Unmapped access not answered with an error.");

    a_clear_refused: assert property (
        (wr_done && hit_fqc && st_ff.flag && (!st_ff.flag_armed || reload_now)) |=> st_ff.flag)
        else $error("Flag cleared without a valid read.");

    a_irq_withdrawn: assert property (
        $fell(st_ff.flag) |-> !irq_b)
        else $error("Interrupt stayed after flag clear.");

    a_irq_enable: assert property (
        irq_b |-> (st_ff.rie && st_ff.flag))
        else $error("Interrupt without enable and flag.");

    a_counter_read: assert property (
        (acc_setup && !pwrite && hit_cnt) |=> prdata[CNT_WIDTH-1:0] == $past(st_ff.cnt) && pready)
        else $error("Counter read returned a stale value.");

    a_modulus_load: assert property (
        (reload_now && st_ff.load_okay) |=> st_ff.mod_act == $past(st_ff.mod_buf))
        else $error("Buffered modulus not loaded at reload.");

    a_load_okay_autoclear: assert property (
        (reload_now && st_ff.load_okay && !(wr_ok && hit_enc)) |=> !st_ff.load_okay)
        else $error("Load-okay not cleared after load.");

endmodule

`default_nettype wire

/* test_pwm_generator_b_period_reload.sv */
/*
 * Self-checking bench for the generator B timing core: reload interval,
 * prescaler, modulus buffering, half-cycle reloads, reload flag and interrupt.
 * Assumes the pwmb_pkg package and the pwmb_gen top module are compiled first.
 */
`default_nettype none

module test_pwm_generator_b_period_reload;
    timeunit 1ns;
    timeprecision 1ps;
    import pwmb_pkg::*;

    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic                clk;
    logic                rst_b;
    logic [ADDR_W-1:0]   paddr;
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [DATA_W-1:0]   pwdata;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                multi_generator_mode;
    logic                center_aligned;
    logic [CNT_W-1:0]    counter_b;
    logic                reload_b;
    logic                irq_b;
    int                  n_mismatch;
    int                  tests_run;
    logic [DATA_W-1:0]   q;
    logic                e;

    pwmb_gen dut (
        .clk                  (clk),
        .rst_b                (rst_b),
        .paddr                (paddr),
        .psel                 (psel),
        .penable              (penable),
        .pwrite               (pwrite),
        .pwdata               (pwdata),
        .prdata               (prdata),
        .pready               (pready),
        .pslverr              (pslverr),
        .multi_generator_mode (multi_generator_mode),
        .center_aligned       (center_aligned),
        .counter_b            (counter_b),
        .reload_b             (reload_b),
        .irq_b                (irq_b)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic tally_and_finish();
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // The request is held until pready is seen high; the single wait state is checked, not assumed.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        check(n, 2);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, r, x);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        x;
        apb(1'b0, a, 32'h0000_0000, r, x);
        check(r, exp);
    endtask

    task automatic wait_reload(output int n);
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (reload_b !== 1'b1 && n < 40000);
    endtask

    // Two reloads are skipped so that any buffered change has settled first.
    task automatic gap(input int exp);
        int n;
        wait_reload(n);
        wait_reload(n);
        wait_reload(n);
        check(n, exp);
    endtask

    task automatic load_ok();
        apb(1'b0, ADDR_ENABLE_CTRL, 32'h0000_0000, q, e);
        wr(ADDR_ENABLE_CTRL, 32'h0000_0083);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_lock_and_map();
        rd_chk(ADDR_ENABLE_CTRL, 32'h0000_0000);
        rd_chk(ADDR_FREQ_CTRL, 32'h0000_0000);
        wr(ADDR_MODULUS, 32'h0000_0005);
        wr(ADDR_FREQ_CTRL, 32'h0000_00f6);
        rd_chk(ADDR_MODULUS, 32'h0000_0000);
        rd_chk(ADDR_FREQ_CTRL, 32'h0000_0000);
        multi_generator_mode <= 1'b1;
        wr(ADDR_MODULUS, 32'h0000_0005);
        rd_chk(ADDR_MODULUS, 32'h0000_0005);
        apb(1'b0, 12'h0fc, 32'h0000_0000, q, e);
        check(e, 1'b1);
    endtask

    task automatic t_start();
        // The reset modulus of zero makes the first period span the full counter range.
        wr(ADDR_MODULUS, 32'h0000_0004);
        load_ok();
        gap(4);
        rd_chk(ADDR_ENABLE_CTRL, 32'h0000_0081);
        wr(ADDR_COUNTER, 32'h0000_7fff);
        apb(1'b0, ADDR_COUNTER, 32'h0000_0000, q, e);
        check(q < 4, 1'b1);
    endtask

    task automatic t_interval();
        int codes[3] = '{0, 1, 15};
        foreach (codes[i]) begin
            wr(ADDR_FREQ_CTRL, codes[i] << 4);
            apb(1'b0, ADDR_FREQ_CTRL, 32'h0000_0000, q, e);
            check(q & 32'h0000_00fe, codes[i] << 4);
            gap(4 * (codes[i] + 1));
        end
        wr(ADDR_FREQ_CTRL, 32'h0000_0000);
    endtask

    task automatic t_prescaler();
        for (int p = 1; p < 4; p++) begin
            wr(ADDR_FREQ_CTRL, p << 1);
            rd_chk(ADDR_FREQ_CTRL, (p << 1) | 1);
            gap(4 << (p - 1));
            load_ok();
            gap(4 << p);
        end
        wr(ADDR_FREQ_CTRL, 32'h0000_0000);
        load_ok();
        gap(4);
    endtask

    task automatic t_modulus_and_half();
        wr(ADDR_MODULUS, 32'h0000_0006);
        rd_chk(ADDR_MODULUS, 32'h0000_0006);
        gap(4);
        load_ok();
        gap(6);
        center_aligned <= 1'b1;
        gap(12);
        wr(ADDR_FREQ_CTRL, 32'h0000_0008);
        gap(6);
        center_aligned <= 1'b0;
        gap(6);
    endtask

    // A long reload interval leaves room for the read-then-write clearing sequence.
    task automatic t_flag_and_irq();
        int n;
        wr(ADDR_FREQ_CTRL, 32'h0000_00f0);
        wait_reload(n);
        wait_reload(n);
        repeat (2) @(posedge clk);
        check(irq_b, 1'b1);
        rd_chk(ADDR_FREQ_CTRL, 32'h0000_00f1);
        wr(ADDR_FREQ_CTRL, 32'h0000_00f1);
        repeat (2) @(posedge clk);
        check(irq_b, 1'b0);
        rd_chk(ADDR_FREQ_CTRL, 32'h0000_00f0);
        wait_reload(n);
        rd_chk(ADDR_FREQ_CTRL, 32'h0000_00f1);
        wait_reload(n);
        wr(ADDR_FREQ_CTRL, 32'h0000_00f1);
        rd_chk(ADDR_FREQ_CTRL, 32'h0000_00f1);
        wr(ADDR_ENABLE_CTRL, 32'h0000_0080);
        repeat (2) @(posedge clk);
        check(irq_b, 1'b0);
        wr(ADDR_ENABLE_CTRL, 32'h0000_0081);
        repeat (2) @(posedge clk);
        check(irq_b, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        n_mismatch = 0;
        tests_run = 0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        multi_generator_mode = 1'b0;
        center_aligned = 1'b0;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        t_lock_and_map();
        t_start();
        t_interval();
        t_prescaler();
        t_modulus_and_half();
        t_flag_and_irq();
        tally_and_finish();
    end

    initial begin
        #(2_000_000);
        n_mismatch++;
        tally_and_finish();
    end

endmodule

`default_nettype wire
